// *** lss_pkg.sv ***
// Package for the line and supply supervisor: timing constants, modes and carriers
package lss_pkg;

  localparam int unsigned CLK_HZ = 100_000_000;

  // Times in their own units, cycle counts derived (least times round up)
  localparam int unsigned BROWNOUT_MS = 54;
  localparam int unsigned HIGH_TO_LOW_MS = 54;
  localparam int unsigned LOW_TO_HIGH_US = 300;
  localparam int unsigned FAULT_BLANK_NS = 30000;
  localparam int unsigned OVERLOAD_MS = 80;

  localparam int unsigned BROWNOUT_CYC = BROWNOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned HIGH_TO_LOW_CYC = HIGH_TO_LOW_MS * (CLK_HZ / 1000);
  localparam int unsigned LOW_TO_HIGH_CYC = LOW_TO_HIGH_US * (CLK_HZ / 1_000_000);
  localparam int unsigned FAULT_BLANK_CYC = (FAULT_BLANK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned OVERLOAD_CYC = OVERLOAD_MS * (CLK_HZ / 1000);

  localparam int TMR_W = 24;

  // On-time limit divisor in high-line mode
  localparam logic [1:0] HIGH_LINE_ON_DIV = 2'h3;
  localparam logic [1:0] LOW_LINE_ON_DIV = 2'h1;

  // Supply sequencer states
  typedef enum logic [1:0] {
    LSS_CHARGE = 2'b00,
    LSS_RUN = 2'b01,
    LSS_FAULT = 2'b10,
    LSS_LATCH = 2'b11
  } lss_state_t;

  // Comparator outputs, grouped
  typedef struct packed {
    logic vcc_on;       // Supply above turn-on level
    logic vcc_off;      // Supply above minimum operating level
    logic vcc_inhibit;  // Supply above inhibit level
    logic supply_overvoltage_level;      // Supply above supply_overvoltage_level
    logic bo_start;     // Line above brownout_start_level
    logic bo_stop;      // Line above brownout_stop_level
    logic drv_disable;  // Line above drive_disable_level
    logic line_sel;     // Line above line_select_level
    logic fault_upper;  // Fault input above upper threshold
    logic fault_lower;  // Fault input below lower threshold
    logic cs_limit;     // Flyback current sense at cycle limit
  } lss_cmp_t;

  // Sequencer outputs, grouped
  typedef struct packed {
    logic startup_en;    // Startup current source on
    logic startup_full;  // Full startup current selected
    logic pfc_en;        // Power-factor stage enabled
    logic flyback_en;    // Flyback stage enabled
    logic high_line;     // High-line mode
    logic [1:0] on_div;  // Maximum on-time divisor
  } lss_ctl_t;

endpackage

// *** lss_sync.sv ***
// Two-stage synchroniser for a vector of comparator levels
`timescale 1ns/1ns
module lss_sync #(
  parameter int W = 11
) (
  input wire logic ref_clk,      // System clock
  input wire logic nrst,         // Async reset, active low
  input wire logic [W-1:0] d,    // Raw levels
  output logic [W-1:0] q         // Synchronised levels
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;

  // First stage feeds only the second
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end

  assign q = s2_r;

endmodule

// *** lss_timer.sv ***
// Run-while-enabled cycle counter with an expiry flag held until run drops
`timescale 1ns/1ns
module lss_timer #(
  parameter int unsigned LIMIT = 16
) (
  input wire logic ref_clk,   // System clock
  input wire logic nrst,      // Async reset, active low
  input wire logic run,       // Count while high, clear when low
  output logic expired        // High once LIMIT cycles counted
);

  localparam logic [lss_pkg::TMR_W-1:0] LIM = lss_pkg::TMR_W'(LIMIT);

  logic [lss_pkg::TMR_W-1:0] cnt_r;
  logic [lss_pkg::TMR_W-1:0] cnt_nxt;

  // Saturates at the limit so expiry holds while run stays high
  always_comb begin
    cnt_nxt = cnt_r;
    if (!run) begin
      cnt_nxt = '0;
    end else if (cnt_r != LIM) begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign expired = (cnt_r == LIM);

endmodule

// *** lss_supervisor.sv ***
// Line and supply supervisor: startup, brown-out, line mode and fault sequencing
// Function
// - At supply turn-on level, switch startup source off and enable controller.
// - Source stays off until supply below minimum; then disable stages, recharge.
// - Below inhibit level select low startup current, else full startup current.
// - While flyback enabled, supply overvoltage latches the controller off.
// - Any fault disables; restart at next turn-on with non-latching faults cleared.
// - Flyback enabled only with line above brown-out start and supply turned on.
// - Line rising across brown-out start enables startup source immediately, except while running.
// - Line below brown-out stop starts a 54 ms brown-out timer.
// - After timer expiry, disable both stages once line below drive-disable level.
// - Line mode starts in low-line after power-up.
// - Go high-line only after line above select level for over 300 us.
// - After high-to-low, inhibit low-to-high timer until line dips below stop.
// - High-line: 54 ms timer runs below select level, resets above, expiry to low.
// - High-line mode cuts maximum on-time limit to one third.
// - Fault inputs confirmed only after persisting for the 30 us blanking delay.
// - Overload timer of 80 ms at current limit; expiry is an overload fault.
`timescale 1ns/1ns
module lss_supervisor (
  input wire logic ref_clk,                 // 100 MHz clock
  input wire logic nrst,                    // Async reset, active low
  input wire lss_pkg::lss_cmp_t cmp,        // Raw comparator levels
  input wire logic latch_lower_fault,       // Lower fault latches when high (option A)
  input wire logic soft_start_done,         // Flyback soft-start finished
  input wire logic thermal_ok,              // Die temperature acceptable
  output lss_pkg::lss_ctl_t ctl,            // Registered control outputs
  output logic fault_latched,               // Controller latched off
  output logic brownout                     // Brown-out shutdown active
);

  lss_pkg::lss_cmp_t cs;
  lss_pkg::lss_state_t st_r;
  lss_pkg::lss_state_t st_nxt;
  lss_pkg::lss_ctl_t ctl_r;
  lss_pkg::lss_ctl_t ctl_nxt;
  logic bo_start_d_r;
  logic bo_start_d_nxt;
  logic bo_off_r;
  logic bo_off_nxt;
  logic hl_inhibit_r;
  logic hl_inhibit_nxt;
  logic bo_exp;
  logic l2h_exp;
  logic h2l_exp;
  logic upper_conf;
  logic lower_conf;
  logic ovld_exp;
  logic stages_on;
  logic ovp_fault;
  logic latch_fault;
  logic any_fault;
  logic lower_run;

  lss_sync #(
    .W($bits(lss_pkg::lss_cmp_t))
  ) u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .d(cmp),
    .q(cs)
  );

  // brown-out timer runs below stop level
  lss_timer #(
    .LIMIT(lss_pkg::BROWNOUT_CYC)
  ) u_bo_tmr (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .run(!cs.bo_stop),
    .expired(bo_exp)
  );

  // low-to-high qualification, held off by inhibit
  lss_timer #(
    .LIMIT(lss_pkg::LOW_TO_HIGH_CYC)
  ) u_l2h_tmr (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .run(cs.line_sel && !ctl_r.high_line && !hl_inhibit_r),
    .expired(l2h_exp)
  );

  // high-to-low timer resets above select level
  lss_timer #(
    .LIMIT(lss_pkg::HIGH_TO_LOW_CYC)
  ) u_h2l_tmr (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .run(!cs.line_sel && ctl_r.high_line),
    .expired(h2l_exp)
  );

  lss_timer #(
    .LIMIT(lss_pkg::FAULT_BLANK_CYC)
  ) u_up_blank (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .run(cs.fault_upper),
    .expired(upper_conf)
  );

  // Lower fault is ignored until soft-start completes, since the pin capacitor is charging
  assign lower_run = cs.fault_lower && soft_start_done;

  lss_timer #(
    .LIMIT(lss_pkg::FAULT_BLANK_CYC)
  ) u_lo_blank (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .run(lower_run),
    .expired(lower_conf)
  );

  lss_timer #(
    .LIMIT(lss_pkg::OVERLOAD_CYC)
  ) u_ovld_tmr (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .run(cs.cs_limit && ctl_r.flyback_en),
    .expired(ovld_exp)
  );

  assign stages_on = (st_r == lss_pkg::LSS_RUN);

  // overvoltage watched only with flyback on
  assign ovp_fault = ctl_r.flyback_en && cs.supply_overvoltage_level;

  // Latching faults; option choice decides the lower fault
  assign latch_fault = ovp_fault || (lower_conf && latch_lower_fault);

  assign any_fault = latch_fault || upper_conf || ovld_exp || lower_conf || !thermal_ok;

  // Brown-out and line-mode bookkeeping
  always_comb begin
    bo_start_d_nxt = cs.bo_start;
    bo_off_nxt = bo_off_r;
    hl_inhibit_nxt = hl_inhibit_r;
    if (bo_exp && !cs.drv_disable) begin
      bo_off_nxt = 1'b1;
    end else if (cs.bo_start) begin
      bo_off_nxt = 1'b0;
    end
    // inhibit clears on a stop-level dip
    if (h2l_exp && ctl_r.high_line) begin
      hl_inhibit_nxt = 1'b1;
    end else if (!cs.bo_stop) begin
      hl_inhibit_nxt = 1'b0;
    end
  end

  // Sequencer next state and control outputs
  always_comb begin
    st_nxt = st_r;
    ctl_nxt = ctl_r;
    case (st_r)
      lss_pkg::LSS_CHARGE: begin
        if (cs.vcc_on && !any_fault) begin
          st_nxt = lss_pkg::LSS_RUN;
        end
      end
      lss_pkg::LSS_RUN: begin
        if (latch_fault) begin
          st_nxt = lss_pkg::LSS_LATCH;
        end else if (any_fault) begin
          st_nxt = lss_pkg::LSS_FAULT;
        end else if (!cs.vcc_off) begin
          st_nxt = lss_pkg::LSS_CHARGE;
        end
      end
      lss_pkg::LSS_FAULT: begin
        // Wait for supply to drop so restart happens at the next turn-on crossing
        if (!cs.vcc_off) begin
          st_nxt = lss_pkg::LSS_CHARGE;
        end
      end
      lss_pkg::LSS_LATCH: begin
        // Only a brown-out releases the latch; supply cycling leaves it set
        if (bo_off_r) begin
          st_nxt = lss_pkg::LSS_CHARGE;
        end
      end
      default: begin
        st_nxt = lss_pkg::LSS_CHARGE;
      end
    endcase
    // startup source off while running; line rise re-enables it
    ctl_nxt.startup_en = (st_nxt == lss_pkg::LSS_CHARGE) ||
                         (cs.bo_start && !bo_start_d_r && st_nxt != lss_pkg::LSS_RUN);
    ctl_nxt.startup_full = cs.vcc_inhibit;
    ctl_nxt.pfc_en = (st_nxt == lss_pkg::LSS_RUN) && !bo_off_nxt;
    // flyback needs line above start and turn-on reached
    ctl_nxt.flyback_en = (st_nxt == lss_pkg::LSS_RUN) && !bo_off_nxt &&
                         (cs.bo_start || ctl_r.flyback_en);
    // switch to high line; expiry returns low
    if (!ctl_r.high_line && l2h_exp) begin
      ctl_nxt.high_line = 1'b1;
    end else if (ctl_r.high_line && h2l_exp) begin
      ctl_nxt.high_line = 1'b0;
    end
    // on-time divided by three in high line
    ctl_nxt.on_div = ctl_nxt.high_line ? lss_pkg::HIGH_LINE_ON_DIV : lss_pkg::LOW_LINE_ON_DIV;
  end

  // Register all sequencer state; low-line at reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= lss_pkg::LSS_CHARGE;
      ctl_r <= '{startup_en: 1'b1, startup_full: 1'b0, pfc_en: 1'b0, flyback_en: 1'b0,
                 high_line: 1'b0, on_div: lss_pkg::LOW_LINE_ON_DIV};
      bo_start_d_r <= 1'b0;
      bo_off_r <= 1'b0;
      hl_inhibit_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      ctl_r <= ctl_nxt;
      bo_start_d_r <= bo_start_d_nxt;
      bo_off_r <= bo_off_nxt;
      hl_inhibit_r <= hl_inhibit_nxt;
    end
  end

  assign ctl = ctl_r;
  assign fault_latched = (st_r == lss_pkg::LSS_LATCH);
  assign brownout = bo_off_r;
  // Stage-on view kept for readability of the run condition
  logic unused_ok;
  assign unused_ok = stages_on;

endmodule

// *** lss_cmp_model.sv ***
// Comparator model standing in for the analog supply and line sensing
`timescale 1ns/1ns
module lss_cmp_model #(
  parameter int INHIBIT_MV = 1500 // Supply inhibit level in mV, plain default
) (
  input wire logic [15:0] vcc_mv, // Supply in millivolts
  input wire logic [9:0] line_v, // Line sense in volts
  input wire logic flt_hi, // Fault input above upper threshold
  input wire logic flt_lo, // Fault input below lower threshold
  input wire logic cs_lim, // Current sense at limit
  output lss_pkg::lss_cmp_t cmp // Comparator levels
);
  // Bare thresholds: no hysteresis, so the block alone must filter noise
  always_comb begin
    cmp.vcc_on = vcc_mv > 16'h4268;
    cmp.vcc_off = vcc_mv > 16'h2260;
    cmp.vcc_inhibit = vcc_mv > INHIBIT_MV[15:0];
    cmp.supply_overvoltage_level = vcc_mv > 16'h6D60;
    cmp.bo_start = line_v > 10'h06F;
    cmp.bo_stop = line_v > 10'h065;
    cmp.drv_disable = line_v > 10'h01E;
    cmp.line_sel = line_v > 10'h0F0;
    cmp.fault_upper = flt_hi;
    cmp.fault_lower = flt_lo;
    cmp.cs_limit = cs_lim;
  end
endmodule

// *** lss_supervisor_asserts.sv ***
// Concurrent checks on the supervisor's ports
`timescale 1ns/1ns
module lss_supervisor_asserts (
  input wire logic ref_clk, // 100 MHz clock
  input wire logic nrst, // Async reset, active low
  input wire lss_pkg::lss_cmp_t cmp, // Raw comparator levels
  input wire logic latch_lower_fault, // Lower fault option
  input wire logic soft_start_done, // Soft-start finished
  input wire logic thermal_ok, // Temperature fine
  input wire lss_pkg::lss_ctl_t ctl, // Control outputs
  input wire logic fault_latched, // Latched off
  input wire logic brownout // Brown-out shutdown
);
  logic [15:0] sel_cnt_r;
  logic [15:0] sel_cnt_nxt;
  // Run length of line above select level, saturating so it never wraps
  always_comb begin
    sel_cnt_nxt = !cmp.line_sel ? 16'h0000 : (&sel_cnt_r) ? sel_cnt_r : sel_cnt_r + 16'h0001;
  end
  // Register the run length
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) sel_cnt_r <= 16'h0000;
    else sel_cnt_r <= sel_cnt_nxt;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Overvoltage seen long enough to pass the synchroniser
  sequence s_ovp_run;
    (ctl.flyback_en && cmp.supply_overvoltage_level) [*3];
  endsequence
  // Supply below minimum while running
  sequence s_supply_low;
    (ctl.flyback_en && !cmp.vcc_off) [*3];
  endsequence
  a_fly_needs_on: assert property (
    $rose(ctl.flyback_en) |-> $past(cmp.vcc_on, 2) && $past(cmp.bo_start, 2))
    else $error("flyback enabled without turn-on and line");
  a_run_src_off: assert property (ctl.flyback_en |-> !ctl.startup_en)
    else $error("startup source on while running");
  a_supply_drop: assert property (
    s_supply_low |-> ##[0:3] (ctl.startup_en && !ctl.flyback_en && !ctl.pfc_en))
    else $error("no recharge after supply drop");
  a_low_current: assert property (!cmp.vcc_inhibit [*4] |-> !ctl.startup_full)
    else $error("full startup current below inhibit");
  a_ovp_latch: assert property (s_ovp_run |-> ##[0:4] fault_latched)
    else $error("overvoltage did not latch");
  a_latch_stops: assert property (
    fault_latched && $past(fault_latched) |-> !ctl.pfc_en && !ctl.flyback_en)
    else $error("stage running while latched");
  a_brown_stops: assert property (
    brownout && $past(brownout) |-> !ctl.pfc_en && !ctl.flyback_en)
    else $error("stage running in brown-out");
  a_high_time: assert property (
    $rose(ctl.high_line) |-> sel_cnt_r >= 16'(lss_pkg::LOW_TO_HIGH_CYC))
    else $error("high line entered too early");
  a_on_div_mode: assert property (ctl.on_div == (ctl.high_line ? 2'h3 : 2'h1))
    else $error("on-time divisor wrong for mode");
endmodule

// *** tb_top.sv ***
// Self-checking bench for the line and supply supervisor
`timescale 1ns/1ns
module tb_top;
  logic ref_clk;
  logic nrst;
  logic [15:0] vcc_mv;
  logic [9:0] line_v;
  logic flt_hi;
  logic flt_lo;
  logic thermal_ok;
  logic on_lvl;
  lss_pkg::lss_cmp_t cmp;
  lss_pkg::lss_ctl_t ctl;
  logic fault_latched;
  logic brownout;
  int error_cnt;
  int n_compared;
  lss_cmp_model u_cmp (.vcc_mv(vcc_mv), .line_v(line_v), .flt_hi(flt_hi), .flt_lo(flt_lo),
    .cs_lim(1'b0), .cmp(cmp));
  lss_supervisor uut (.ref_clk(ref_clk), .nrst(nrst), .cmp(cmp), .latch_lower_fault(1'b0),
    .soft_start_done(on_lvl), .thermal_ok(thermal_ok), .ctl(ctl), .fault_latched(fault_latched),
    .brownout(brownout));
  // Free-running 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Compare one observed value with its expectation
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Status: source, pfc, flyback, high line, divisor, latched
  function automatic logic [7:0] sts();
    return {1'b0, ctl.startup_en, ctl.pfc_en, ctl.flyback_en, ctl.high_line, ctl.on_div,
      fault_latched};
  endfunction
  // Set supply and line at a falling edge, then let n cycles pass
  task automatic go(input logic [15:0] v, input logic [9:0] l, input int n);
    vcc_mv = v;
    line_v = l;
    repeat (n) @(negedge ref_clk);
  endtask
  // Restart through a full supply cycle
  task automatic recycle();
    go(16'h1388, 10'h078, 6);
    go(16'h4650, 10'h078, 6);
  endtask
  // Print counts and verdict, then stop
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Cut a hang short; the full sequence needs well under 90,000 cycles
  initial begin
    #900000;
    error_cnt++;
    results();
  end
  // Main sequence
  initial begin
    error_cnt = 0;
    n_compared = 0;
    nrst = 1'b0;
    flt_hi = 1'b0;
    flt_lo = 1'b0;
    thermal_ok = 1'b1;
    on_lvl = 1'b1;
    go(16'h0000, 10'h000, 3);
    chk(sts(), 8'h42);
    nrst = 1'b1;
    go(16'h03E8, 10'h078, 6);
    chk({7'h0, ctl.startup_full}, 8'h00);
    go(16'h2EE0, 10'h078, 6);
    chk({7'h0, ctl.startup_full}, 8'h01);
    chk(sts(), 8'h42);
    $display("test startup current done");
    go(16'h4650, 10'h078, 6);
    chk(sts(), 8'h32);
    go(16'h2EE0, 10'h078, 6);
    chk(sts(), 8'h32);
    go(16'h1388, 10'h078, 6);
    chk(sts(), 8'h42);
    go(16'h4650, 10'h032, 6);
    chk({7'h0, ctl.flyback_en}, 8'h00);
    chk({7'h0, brownout}, 8'h00);
    recycle();
    chk(sts(), 8'h32);
    $display("test supply sequencing done");
    flt_hi = 1'b1;
    go(16'h4650, 10'h078, 2000);
    chk(sts(), 8'h32);
    go(16'h4650, 10'h078, 1200);
    chk({ctl.pfc_en, ctl.flyback_en}, 8'h00);
    flt_hi = 1'b0;
    go(16'h4650, 10'h078, 6);
    chk({ctl.pfc_en, ctl.flyback_en}, 8'h00);
    recycle();
    chk(sts(), 8'h32);
    flt_lo = 1'b1;
    go(16'h4650, 10'h078, 3100);
    chk({ctl.pfc_en, ctl.flyback_en, fault_latched}, 8'h00);
    flt_lo = 1'b0;
    recycle();
    chk(sts(), 8'h32);
    thermal_ok = 1'b0;
    go(16'h4650, 10'h078, 6);
    chk({ctl.pfc_en, ctl.flyback_en}, 8'h00);
    thermal_ok = 1'b1;
    recycle();
    chk(sts(), 8'h32);
    $display("test faults done");
    go(16'h4650, 10'h0FA, 20000);
    go(16'h4650, 10'h0C8, 10);
    go(16'h4650, 10'h0FA, 20000);
    chk(sts(), 8'h32);
    go(16'h4650, 10'h0FA, 10010);
    chk(sts(), 8'h3E);
    go(16'h4650, 10'h0C8, 1000);
    go(16'h4650, 10'h0FA, 6);
    chk(sts(), 8'h3E);
    $display("test line mode done");
    go(16'h7148, 10'h0FA, 8);
    chk({fault_latched, ctl.pfc_en, ctl.flyback_en}, 8'h04);
    go(16'h1388, 10'h0FA, 6);
    go(16'h4650, 10'h0FA, 6);
    chk({fault_latched, ctl.pfc_en, ctl.flyback_en}, 8'h04);
    $display("test overvoltage done");
    results();
  end
endmodule
bind lss_supervisor lss_supervisor_asserts u_chk (.ref_clk(ref_clk), .nrst(nrst), .cmp(cmp),
  .latch_lower_fault(latch_lower_fault), .soft_start_done(soft_start_done),
  .thermal_ok(thermal_ok), .ctl(ctl), .fault_latched(fault_latched), .brownout(brownout));
